// ==== verilog/port_cmd_pkg.sv ====
package port_cmd_pkg;

    // function codes
    localparam logic [7:0] FC_WRITE_ONE = 8'h05;
    localparam logic [7:0] FC_LOOPBACK  = 8'h08;
    localparam logic [7:0] FC_EVENT_LOG = 8'h0c;
    localparam logic [7:0] FC_PRESET    = 8'h10;
    localparam logic [7:0] FC_ERR_FLAG  = 8'h80;

    // exception codes of an error reply
    localparam logic [7:0] EX_FUNC    = 8'h01;
    localparam logic [7:0] EX_ADDR    = 8'h02;
    localparam logic [7:0] EX_REFUSED = 8'h04;

    // check word: x16+x15+x2+1, bit reversed, preset to all ones
    localparam logic [15:0] CRC_POLY   = 16'ha001;
    localparam logic [15:0] CRC_PRESET = 16'hffff;

    // address map
    localparam logic [15:0] ADDR_BIAS   = 16'h0001;
    localparam logic [15:0] REAL_IO_END = 16'h00ff;
    localparam logic [15:0] REG_BASE    = 16'h1000;

    // frame layout
    localparam logic [8:0]  MIN_FRAME     = 9'h004;
    localparam logic [8:0]  WRITE1_FRAME  = 9'h008;
    localparam logic [16:0] PRESET_OVHD   = 17'h00009;
    localparam logic [8:0]  WRITE1_DATA   = 9'h004;
    localparam logic [8:0]  PRESET_DATA   = 9'h007;
    localparam logic [8:0]  ECHO_LEN      = 9'h006;
    localparam logic [8:0]  ERR_LEN       = 9'h003;
    localparam logic [8:0]  LOG_HDR_LEN   = 9'h009;
    localparam logic [8:0]  CRC_LEN       = 9'h002;
    localparam int          HDR_BYTES     = 7;

    // register port
    localparam logic [3:0]  OFS_CTRL      = 4'h0;
    localparam logic [3:0]  OFS_STATUS    = 4'h1;
    localparam logic [3:0]  OFS_MASK      = 4'h2;
    localparam logic [3:0]  OFS_EV_COUNT  = 4'h3;
    localparam logic [3:0]  OFS_MSG_COUNT = 4'h4;
    localparam logic [3:0]  OFS_EV_STATUS = 4'h5;
    localparam logic [3:0]  OFS_TBL_ADDR  = 4'h6;
    localparam logic [3:0]  OFS_TBL_DATA  = 4'h7;
    localparam logic [15:0] CTRL_RESET    = 16'h0101;
    localparam int          CTRL_PROTECT  = 0;
    localparam int          CTRL_NODE_LSB = 8;

    // interrupt status bits
    localparam int IRQ_DONE   = 0;
    localparam int IRQ_CRC    = 1;
    localparam int IRQ_REFUSE = 2;
    localparam int IRQ_BITS   = 3;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } rx_byte_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
        logic [15:0] data;
    } push_t;

    typedef enum logic [2:0] {
        S_RX      = 3'b000,
        S_CHECK   = 3'b001,
        S_WR_HI   = 3'b010,
        S_WR_LO   = 3'b011,
        S_WR_DO   = 3'b100,
        S_TX_RD   = 3'b101,
        S_TX_LOAD = 3'b110,
        S_TX_WAIT = 3'b111
    } state_t;

endpackage : port_cmd_pkg

// ==== verilog/crc16_calc.sv ====
`timescale 1ns/1ps
`default_nettype none
module crc16_calc (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // byte feed
    input  wire logic        clr,
    input  wire logic        en,
    input  wire logic [7:0]  data,
    // running check word
    output logic [15:0] crc
);
    logic [15:0] next_crc;

    always_comb begin
        next_crc = crc ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            if (next_crc[0]) begin
                next_crc = (next_crc >> 1) ^ port_cmd_pkg::CRC_POLY;
            end else begin
                next_crc = next_crc >> 1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst || clr) begin
            crc <= port_cmd_pkg::CRC_PRESET;
        end else if (en) begin
            crc <= next_crc;
        end
    end
endmodule : crc16_calc
`default_nettype wire

// ==== verilog/word_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
module word_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 256,
    parameter int AW    = $clog2(DEPTH)
) (
    // clock
    input  wire logic             clk,
    // single access port, read data registered
    input  wire logic             we,
    input  wire logic [AW-1:0]    addr,
    input  wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [0:DEPTH-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule : word_mem
`default_nettype wire

// ==== verilog/port_cmd_handler.sv ====
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module port_cmd_handler #(
    parameter int          TABLE_DEPTH = 256,
    parameter int          LOG_DEPTH   = 8,
    parameter logic [15:0] REAL_IO_END = port_cmd_pkg::REAL_IO_END
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // received bytes and end of frame from the serial receiver
    input  wire port_cmd_pkg::rx_byte_t  rx,
    input  wire logic                    rx_end,
    // response bytes to the serial transmitter
    output logic [7:0]              tx_data,
    output logic                    tx_valid,
    input  wire logic                    tx_ready,
    // processor module
    input  wire logic                    run_mode,
    output port_cmd_pkg::push_t     push,
    // register port
    input  wire logic [3:0]              reg_addr,
    input  wire logic [15:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic [15:0]             reg_rdata,
    // interrupt
    output logic                    irq
);
    localparam int TAW = $clog2(TABLE_DEPTH);

    port_cmd_pkg::state_t state;
    logic [8:0]  rx_cnt;
    logic [8:0]  rd_ptr;
    logic [8:0]  pay_n;
    logic        tx_echo;
    logic [7:0]  ex_code_q;
    logic        err_reply;
    logic [15:0] wr_addr;
    logic [15:0] words;
    logic        wr_rio;
    logic [7:0]  data_hi;
    logic [7:0]  hdr [0:port_cmd_pkg::HDR_BYTES-1];
    logic [LOG_DEPTH-1:0][7:0] log_q;
    logic [15:0] ev_count;
    logic [15:0] msg_count;
    logic [15:0] ev_status;
    logic [15:0] ctrl;
    logic [15:0] tbl_sw_addr;
    logic [port_cmd_pkg::IRQ_BITS-1:0] status;
    logic [port_cmd_pkg::IRQ_BITS-1:0] mask;
    logic [15:0] crc;
    logic [7:0]  fbuf_rdata;
    logic [15:0] tbl_rdata;
    logic [7:0]  gen_byte;

    // configuration
    wire logic [7:0] node_addr     = ctrl[port_cmd_pkg::CTRL_NODE_LSB +: 8];
    wire logic       write_protect = ctrl[port_cmd_pkg::CTRL_PROTECT];

    // header decode
    wire logic [7:0]  fc         = hdr[1];
    wire logic [15:0] start_addr = {hdr[2], hdr[3]}
                                 + port_cmd_pkg::ADDR_BIAS;
    wire logic [15:0] word_cnt   = {hdr[4], hdr[5]};
    wire logic [15:0] tbl_off    = start_addr - port_cmd_pkg::REG_BASE;
    wire logic        in_rio     = start_addr <= REAL_IO_END;
    wire logic        in_tbl     = start_addr >= port_cmd_pkg::REG_BASE
                                 && tbl_off < 16'(TABLE_DEPTH);
    wire logic        frame_ok   = crc == 16'h0000 && !rx_cnt[8]
                                 && rx_cnt >= port_cmd_pkg::MIN_FRAME;
    wire logic        node_ok    = hdr[0] == node_addr;
    wire logic        is_write1  = fc == port_cmd_pkg::FC_WRITE_ONE;
    wire logic        is_preset  = fc == port_cmd_pkg::FC_PRESET;
    wire logic        is_loop    = fc == port_cmd_pkg::FC_LOOPBACK;
    wire logic        is_log     = fc == port_cmd_pkg::FC_EVENT_LOG;
    wire logic        preset_fits = in_tbl && word_cnt != 16'h0000
                                 && word_cnt[15:8] == 8'h00
                                 && {1'b0, tbl_off} + {1'b0, word_cnt}
                                    <= 17'(TABLE_DEPTH)
                                 && {8'h00, rx_cnt} >= port_cmd_pkg::PRESET_OVHD
                                    + {1'b0, word_cnt[14:0], 1'b0};

    // write gating
    wire logic refuse = (is_write1 && (write_protect
                                    || (in_rio && !run_mode)))
                     || (is_preset && write_protect);
    wire logic bad_addr = (is_write1 && ((!in_rio && !in_tbl)
                        || rx_cnt < port_cmd_pkg::WRITE1_FRAME))
                       || (is_preset && !preset_fits);
    wire logic bad_func = !(is_write1 || is_preset || is_loop || is_log);
    wire logic cmd_err  = bad_func || refuse || bad_addr;
    wire logic [7:0] ex_code = bad_func ? port_cmd_pkg::EX_FUNC
                             : refuse   ? port_cmd_pkg::EX_REFUSED
                             :            port_cmd_pkg::EX_ADDR;
    wire logic [7:0] log_entry = {1'b1, cmd_err, 2'b00, fc[3:0]};
    wire logic accepted = state == port_cmd_pkg::S_CHECK && frame_ok
                       && node_ok;

    // transmit selection, check word sent low byte first
    wire logic [8:0] tx_total = pay_n + port_cmd_pkg::CRC_LEN;
    wire logic tx_last = state == port_cmd_pkg::S_TX_WAIT && tx_ready
                      && rd_ptr == tx_total;
    wire logic [7:0] tx_byte = rd_ptr == pay_n ? crc[7:0]
                             : rd_ptr == pay_n + 9'h001 ? crc[15:8]
                             : tx_echo ? fbuf_rdata
                             : gen_byte;
    wire logic [8:0] log_idx = rd_ptr - port_cmd_pkg::LOG_HDR_LEN;

    always_comb begin
        gen_byte = 8'h00;
        case (rd_ptr)
            9'h000: gen_byte = node_addr;
            9'h001: gen_byte = err_reply ? (fc | port_cmd_pkg::FC_ERR_FLAG)
                                         : fc;
            9'h002: gen_byte = err_reply ? ex_code_q
                                         : 8'(LOG_DEPTH + 6);
            9'h003: gen_byte = ev_status[15:8];
            9'h004: gen_byte = ev_status[7:0];
            9'h005: gen_byte = ev_count[15:8];
            9'h006: gen_byte = ev_count[7:0];
            9'h007: gen_byte = msg_count[15:8];
            9'h008: gen_byte = msg_count[7:0];
            default: gen_byte = log_q[log_idx[7:0]];
        endcase
    end

    // storage
    wire logic       rx_take  = state == port_cmd_pkg::S_RX && rx.valid
                             && !rx_cnt[8];
    wire logic [7:0] fbuf_adr = state == port_cmd_pkg::S_RX ? rx_cnt[7:0]
                                                            : rd_ptr[7:0];
    wire logic       wr_do    = state == port_cmd_pkg::S_WR_DO;
    wire logic       tbl_we   = wr_do && !wr_rio;
    wire logic [15:0] wr_off  = wr_addr - port_cmd_pkg::REG_BASE;
    wire logic [TAW-1:0] tbl_adr = tbl_we ? wr_off[TAW-1:0]
                                          : tbl_sw_addr[TAW-1:0];
    wire logic crc_en = rx_take || (state == port_cmd_pkg::S_TX_LOAD
                                    && rd_ptr < pay_n);
    wire logic crc_clr = state == port_cmd_pkg::S_CHECK || tx_last;

    word_mem #(.WIDTH(8), .DEPTH(256)) frame_buf (
        .clk   (clk),
        .we    (rx_take),
        .addr  (fbuf_adr),
        .wdata (rx.data),
        .rdata (fbuf_rdata)
    );

    word_mem #(.WIDTH(16), .DEPTH(TABLE_DEPTH)) reg_table (
        .clk   (clk),
        .we    (tbl_we),
        .addr  (tbl_adr),
        .wdata ({data_hi, fbuf_rdata}),
        .rdata (tbl_rdata)
    );

    crc16_calc check (
        .clk  (clk),
        .rst  (rst),
        .clr  (crc_clr),
        .en   (crc_en),
        .data (state == port_cmd_pkg::S_RX ? rx.data : tx_byte),
        .crc  (crc)
    );

    // header bytes held in flops so decode needs no memory read
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < port_cmd_pkg::HDR_BYTES; i++) begin
                hdr[i] <= 8'h00;
            end
        end else if (rx_take && rx_cnt < 9'(port_cmd_pkg::HDR_BYTES)) begin
            hdr[rx_cnt[2:0]] <= rx.data;
        end
    end

    // receiver is deaf outside S_RX, as the link is half duplex
    always_ff @(posedge clk) begin
        if (rst) begin
            state     <= port_cmd_pkg::S_RX;
            rx_cnt    <= 9'h000;
            rd_ptr    <= 9'h000;
            pay_n     <= 9'h000;
            tx_echo   <= 1'b0;
            err_reply <= 1'b0;
            ex_code_q <= 8'h00;
            wr_addr   <= 16'h0000;
            words     <= 16'h0000;
            wr_rio    <= 1'b0;
            data_hi   <= 8'h00;
            tx_valid  <= 1'b0;
            tx_data   <= 8'h00;
        end else begin
            case (state)
                port_cmd_pkg::S_RX: begin
                    if (rx_take) begin
                        rx_cnt <= rx_cnt + 9'h001;
                    end
                    if (rx_end && rx_cnt != 9'h000) begin
                        state <= port_cmd_pkg::S_CHECK;
                    end
                end
                port_cmd_pkg::S_CHECK: begin
                    rx_cnt    <= 9'h000;
                    rd_ptr    <= 9'h000;
                    err_reply <= cmd_err;
                    ex_code_q <= ex_code;
                    wr_addr   <= start_addr;
                    wr_rio    <= is_write1 && in_rio;
                    tx_echo   <= !cmd_err && !is_log;
                    pay_n     <= port_cmd_pkg::ECHO_LEN;
                    if (!accepted) begin
                        state <= port_cmd_pkg::S_RX;
                    end else if (cmd_err) begin
                        pay_n <= port_cmd_pkg::ERR_LEN;
                        state <= port_cmd_pkg::S_TX_RD;
                    end else if (is_loop) begin
                        pay_n <= rx_cnt - port_cmd_pkg::CRC_LEN;
                        state <= port_cmd_pkg::S_TX_RD;
                    end else if (is_log) begin
                        pay_n <= port_cmd_pkg::LOG_HDR_LEN + 9'(LOG_DEPTH);
                        state <= port_cmd_pkg::S_TX_RD;
                    end else if (is_write1) begin
                        words  <= 16'h0001;
                        rd_ptr <= port_cmd_pkg::WRITE1_DATA;
                        state  <= port_cmd_pkg::S_WR_HI;
                    end else begin
                        words  <= word_cnt;
                        rd_ptr <= port_cmd_pkg::PRESET_DATA;
                        state  <= port_cmd_pkg::S_WR_HI;
                    end
                end
                port_cmd_pkg::S_WR_HI: begin
                    rd_ptr <= rd_ptr + 9'h001;
                    state  <= port_cmd_pkg::S_WR_LO;
                end
                port_cmd_pkg::S_WR_LO: begin
                    data_hi <= fbuf_rdata;
                    rd_ptr  <= rd_ptr + 9'h001;
                    state   <= port_cmd_pkg::S_WR_DO;
                end
                port_cmd_pkg::S_WR_DO: begin
                    wr_addr <= wr_addr + 16'h0001;
                    words   <= words - 16'h0001;
                    if (words == 16'h0001) begin
                        rd_ptr <= 9'h000;
                        state  <= port_cmd_pkg::S_TX_RD;
                    end else begin
                        state <= port_cmd_pkg::S_WR_HI;
                    end
                end
                port_cmd_pkg::S_TX_RD: begin
                    state <= port_cmd_pkg::S_TX_LOAD;
                end
                port_cmd_pkg::S_TX_LOAD: begin
                    tx_data  <= tx_byte;
                    tx_valid <= 1'b1;
                    rd_ptr   <= rd_ptr + 9'h001;
                    state    <= port_cmd_pkg::S_TX_WAIT;
                end
                port_cmd_pkg::S_TX_WAIT: begin
                    if (tx_ready) begin
                        tx_valid <= 1'b0;
                        state    <= tx_last ? port_cmd_pkg::S_RX
                                            : port_cmd_pkg::S_TX_RD;
                    end
                end
                default: state <= port_cmd_pkg::S_RX;
            endcase
        end
    end

    // real I/O is reached only through the processor, never stored here
    always_ff @(posedge clk) begin
        if (rst) begin
            push <= '0;
        end else begin
            push.valid <= wr_do && wr_rio;
            push.addr  <= wr_addr;
            push.data  <= {data_hi, fbuf_rdata};
        end
    end

    // communication event bookkeeping
    always_ff @(posedge clk) begin
        if (rst) begin
            log_q     <= '0;
            ev_count  <= 16'h0000;
            msg_count <= 16'h0000;
            ev_status <= 16'h0000;
        end else if (accepted) begin
            log_q     <= {log_q[LOG_DEPTH-2:0], log_entry};
            msg_count <= msg_count + 16'h0001;
            ev_status <= {8'h00, log_entry};
            if (!cmd_err) begin
                ev_count <= ev_count + 16'h0001;
            end
        end
    end

    // register port and interrupt
    wire logic wr_ctrl   = reg_wr && reg_addr == port_cmd_pkg::OFS_CTRL;
    wire logic wr_status = reg_wr && reg_addr == port_cmd_pkg::OFS_STATUS;
    wire logic wr_mask   = reg_wr && reg_addr == port_cmd_pkg::OFS_MASK;
    wire logic wr_tbl    = reg_wr && reg_addr == port_cmd_pkg::OFS_TBL_ADDR;
    wire logic [port_cmd_pkg::IRQ_BITS-1:0] ev_set = {
        accepted && refuse,
        state == port_cmd_pkg::S_CHECK && !frame_ok,
        tx_last};
    wire logic [port_cmd_pkg::IRQ_BITS-1:0] w1c =
        wr_status ? reg_wdata[port_cmd_pkg::IRQ_BITS-1:0] : '0;
    // set wins over a clear in the same cycle
    wire logic [port_cmd_pkg::IRQ_BITS-1:0] next_status =
        (status & ~w1c) | ev_set;
    // irq follows a mask write at the same edge as a status clear
    wire logic [port_cmd_pkg::IRQ_BITS-1:0] next_mask =
        wr_mask ? reg_wdata[port_cmd_pkg::IRQ_BITS-1:0] : mask;
    wire logic [15:0] rd_mux =
        reg_addr == port_cmd_pkg::OFS_CTRL      ? ctrl
      : reg_addr == port_cmd_pkg::OFS_STATUS    ? 16'(status)
      : reg_addr == port_cmd_pkg::OFS_MASK      ? 16'(mask)
      : reg_addr == port_cmd_pkg::OFS_EV_COUNT  ? ev_count
      : reg_addr == port_cmd_pkg::OFS_MSG_COUNT ? msg_count
      : reg_addr == port_cmd_pkg::OFS_EV_STATUS ? ev_status
      : reg_addr == port_cmd_pkg::OFS_TBL_ADDR  ? tbl_sw_addr
      : reg_addr == port_cmd_pkg::OFS_TBL_DATA  ? tbl_rdata
      :                                           16'h0000;

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl        <= port_cmd_pkg::CTRL_RESET;
            status      <= '0;
            mask        <= '0;
            tbl_sw_addr <= 16'h0000;
            reg_rdata   <= 16'h0000;
            irq         <= 1'b0;
        end else begin
            ctrl        <= wr_ctrl ? reg_wdata : ctrl;
            mask        <= next_mask;
            tbl_sw_addr <= wr_tbl ? reg_wdata : tbl_sw_addr;
            status      <= next_status;
            irq         <= |(next_status & next_mask);
            reg_rdata   <= reg_rd ? rd_mux : 16'h0000;
        end
    end
endmodule : port_cmd_handler
`default_nettype wire

// ==== tb/port_cmd_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module port_cmd_chk #(
    parameter logic [15:0] REAL_IO_END = port_cmd_pkg::REAL_IO_END
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // link and processor side
    input  wire logic [7:0]            tx_data,
    input  wire logic                  tx_valid,
    input  wire logic                  tx_ready,
    input  wire logic                  run_mode,
    input  wire port_cmd_pkg::push_t   push,
    // register port and interrupt
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    input  wire logic [15:0]           reg_rdata,
    input  wire logic                  irq
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence held_byte;
        tx_valid && !tx_ready;
    endsequence
    sequence taken_byte;
        tx_valid && tx_ready;
    endsequence
    tx_hold_a: assert property (
        held_byte |=> tx_valid && $stable(tx_data))
        else $error("reply byte dropped before accept");
    tx_gap_a: assert property (
        taken_byte |=> !tx_valid [*2])
        else $error("next reply byte too early");
    push_pulse_a: assert property (
        push.valid |=> !push.valid)
        else $error("push longer than one cycle");
    push_run_a: assert property (
        push.valid |-> $past(run_mode))
        else $error("push outside run mode");
    push_map_a: assert property (
        push.valid |-> push.addr <= REAL_IO_END)
        else $error("push outside real io");
    push_quiet_a: assert property (
        push.valid |-> !tx_valid)
        else $error("push during reply");
    rd_idle_a: assert property (
        !$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside read cycle");
    irq_drop_a: assert property (
        $fell(irq) |-> $past(reg_wr))
        else $error("interrupt dropped without a write");
endmodule : port_cmd_chk
`default_nettype wire

// ==== tb/rtu_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module rtu_host (
    // clock
    input  wire logic                   clk,
    // link toward the port
    output var port_cmd_pkg::rx_byte_t  rx,
    output logic                        rx_end,
    input  wire logic [7:0]             tx_data,
    input  wire logic                   tx_valid,
    output logic                        tx_ready
);
    logic [7:0] rsp[$];
    logic       slow = 1'b0;
    initial rx = '0;
    initial rx_end = 1'b0;
    initial tx_ready = 1'b0;
    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction : crc16
    // bad spoils the check word on purpose
    task automatic send(input logic [7:0] f[$], input bit bad);
        logic [15:0] c;
        c = crc16(f) ^ {15'h0000, bad};
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        rsp = {};
        foreach (f[i]) begin
            @(posedge clk);
            rx <= '{1'b1, f[i]};
            rx_end <= (i == f.size() - 1);
        end
        @(posedge clk);
        rx <= '{1'b0, ~f[f.size() - 1]};
        rx_end <= 1'b0;
    endtask : send
    // slow host holds tx_ready low every other cycle
    always @(posedge clk) begin
        if (tx_valid && tx_ready)
            rsp.push_back(tx_data);
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end
endmodule : rtu_host
`default_nettype wire

// ==== tb/serial_port_register_command_handler_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module serial_port_register_command_handler_tb;
    logic                   clk = 1'b0;
    logic                   rst = 1'b1;
    port_cmd_pkg::rx_byte_t rx;
    logic                   rx_end, tx_valid, tx_ready, run_mode;
    logic                   reg_wr, reg_rd, irq;
    logic [7:0]             tx_data;
    port_cmd_pkg::push_t    push, pushed;
    logic [3:0]             reg_addr;
    logic [15:0]            reg_wdata, reg_rdata;
    int                     errors = 0;
    int                     tests_run = 0;
    int                     cyc = 0;
    int                     npush = 0;
    logic [7:0] wio[$] = {8'h01, 8'h05, 8'h00, 8'h0f, 8'h12, 8'h34};
    logic [7:0] lb[$] = {8'h01, 8'h08, 8'h00, 8'h00, 8'ha5, 8'h5a};
    always #5 clk = ~clk;
    port_cmd_handler i_dut (.clk(clk), .rst(rst), .rx(rx), .rx_end(rx_end),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .run_mode(run_mode), .push(push), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq));
    rtu_host host (.clk(clk), .rx(rx), .rx_end(rx_end), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready));
    always @(posedge clk)
        if (push.valid) begin
            npush <= npush + 1;
            pushed <= push;
        end
    task automatic complete_run();
        $display("tests_run %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            complete_run();
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, e);
    endtask : rd
    // table data is stale for one cycle after the index moves
    task automatic tbl(input logic [15:0] i, input logic [15:0] e);
        wr(4'h6, i);
        repeat (3) @(posedge clk);
        rd(4'h7, e);
    endtask : tbl
    // reply body given, check word appended here
    task automatic expect_rsp(input logic [7:0] e[$]);
        int          n;
        logic [15:0] c;
        n = 0;
        c = host.crc16(e);
        e.push_back(c[7:0]);
        e.push_back(c[15:8]);
        while (host.rsp.size() < e.size() && n < 600) begin
            @(posedge clk);
            n++;
        end
        check(16'(host.rsp.size()), 16'(e.size()));
        foreach (e[i]) check({8'h00, host.rsp[i]}, {8'h00, e[i]});
        repeat (5) @(posedge clk);
        #1 $display("frame test done at %0t", $time);
    endtask : expect_rsp
    initial begin
        {run_mode, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(4'h0, 16'h0101);
        host.send(wio, 0);
        expect_rsp({8'h01, 8'h85, 8'h04});
        rd(4'h1, 16'h0005);
        wr(4'h2, 16'h0007);
        repeat (2) @(posedge clk);
        #1 check({15'h0000, irq}, 16'h0001);
        wr(4'h1, 16'h0007);
        repeat (2) @(posedge clk);
        #1 check({15'h0000, irq}, 16'h0000);
        wr(4'h2, 16'h0000);
        wr(4'h0, 16'h0100);
        host.send(wio, 0);
        expect_rsp({8'h01, 8'h85, 8'h04});
        check(16'(npush), 16'h0000);
        run_mode <= 1'b1;
        host.send(wio, 0);
        expect_rsp(wio);
        check(16'(npush), 16'h0001);
        check(pushed.addr, 16'h0010);
        check(pushed.data, 16'h1234);
        run_mode <= 1'b0;
        host.send({8'h01, 8'h05, 8'h0f, 8'hff, 8'hbe, 8'hef}, 0);
        expect_rsp({8'h01, 8'h05, 8'h0f, 8'hff, 8'hbe, 8'hef});
        tbl(16'h0000, 16'hbeef);
        host.send({8'h01, 8'h10, 8'h10, 8'h00, 8'h00, 8'h02, 8'h04,
                   8'h11, 8'h11, 8'h22, 8'h22}, 0);
        expect_rsp({8'h01, 8'h10, 8'h10, 8'h00, 8'h00, 8'h02});
        tbl(16'h0001, 16'h1111);
        tbl(16'h0002, 16'h2222);
        wr(4'h0, 16'h0101);
        host.send({8'h01, 8'h10, 8'h10, 8'h00, 8'h00, 8'h01, 8'h02,
                   8'h99, 8'h99}, 0);
        expect_rsp({8'h01, 8'h90, 8'h04});
        tbl(16'h0001, 16'h1111);
        host.slow = 1'b1;
        host.send(lb, 0);
        expect_rsp(lb);
        host.slow = 1'b0;
        host.send({8'h01, 8'h07}, 0);
        expect_rsp({8'h01, 8'h87, 8'h01});
        wr(4'h1, 16'h0007);
        host.send(lb, 1);
        repeat (200) @(posedge clk);
        #1 check(16'(host.rsp.size()), 16'h0000);
        rd(4'h1, 16'h0002);
        host.send({8'h01, 8'h0c}, 0);
        expect_rsp({8'h01, 8'h0c, 8'h0e, 8'h00, 8'h8c, 8'h00, 8'h05,
                    8'h00, 8'h09, 8'h8c, 8'hc7, 8'h88, 8'hc0, 8'h80,
                    8'h85, 8'h85, 8'hc5});
        rd(4'h4, 16'h0009);
        rd(4'h3, 16'h0005);
        complete_run();
    end
endmodule : serial_port_register_command_handler_tb
bind port_cmd_handler port_cmd_chk #(.REAL_IO_END(REAL_IO_END)) i_chk (
    .clk(clk), .rst(rst), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .run_mode(run_mode), .push(push),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
`default_nettype wire
